// >>> hw/odsc_params.svh
// constants for the octal dac serial command logic
`ifndef ODSC_PARAMS_SVH
`define ODSC_PARAMS_SVH
`define ODSC_WORD_BITS 16
`define ODSC_BIT_CMD 15
`define ODSC_ADDR_HI 14
`define ODSC_ADDR_LO 12
`define ODSC_MODE_HI 14
`define ODSC_MODE_LO 13
`define ODSC_BIT_FULLRST 12
`define ODSC_BIT_SUP_AD 0
`define ODSC_BIT_SUP_EH 1
`define ODSC_BIT_BUF_AD 2
`define ODSC_BIT_BUF_EH 3
`define ODSC_BIT_GAIN_AD 4
`define ODSC_BIT_GAIN_EH 5
`define ODSC_RST_LOAD_MODE 2'h1
`define ODSC_RST_CTRL 1'h0
// byte map of the control/status registers
`define ODSC_REG_CTRL 32'h0000_0000
`define ODSC_REG_STATUS 32'h0000_0004
`define ODSC_REG_CODE0 32'h0000_0010
`endif

// >>> hw/odsc_pkg.sv
// types for the octal dac serial command logic
package odsc_pkg;
  typedef enum logic [1:0] {
    ODSC_MODE_REFGAIN,
    ODSC_MODE_LOAD,
    ODSC_MODE_PWRDN,
    ODSC_MODE_RESET
  } odsc_mode_type;
  typedef enum logic [1:0] {
    ODSC_LOAD_CONT,
    ODSC_LOAD_HELD,
    ODSC_LOAD_SINGLE,
    ODSC_LOAD_RSVD
  } odsc_load_type;
endpackage : odsc_pkg

// >>> hw/odsc_top.sv
// serial command front end and register banks of an octal dac
//
// Behaviour
// - a 16-bit shift register collects each frame's word
// - bits are accepted only while the active-low frame select is low
// - data is sampled on each falling shift clock edge, sixteen times
// - at frame end the word goes to an input register or acts as command
// - select rising before the sixteenth edge discards the partial word
// - words arrive msb first; bit 15 picks data write or command
// - data write: bit 15 zero, bits 14:12 choose channel A to H
// - 12, 10 or 8 code bits used by variant; low bits ignored
// - codes are straight binary, zeros is zero volts, ones full scale
// - command: bit 15 one, bits 14:13 select refgain, load, powerdown, reset
// - bits 2 and 3 set buffered reference for groups AD and EH
// - bits 4 and 5 set double gain for groups AD and EH
// - bits 0 and 1 select supply as reference for groups AD and EH
// - supply reference overrides buffer bit, forcing unbuffered
// - supply reference forces unity range regardless of gain bit
// - powered-down channel output floats high impedance
// - power-down keeps registers and still accepts new data
// - after power-on all input and dac registers are zero
// - power-on: channels up, unbuffered, unity gain, load mode held
// - load mode bits 1:0: continuous, held, single update, reserved
// - power-down command powers down every selected channel
// - reset zeroes data; bit 12 set also restores control defaults
// - dac registers follow input registers in continuous mode or load low
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "odsc_params.svh"
module odsc_top #(
  parameter int RES_BITS = 12
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_frame_sel_n,
  input wire logic i_shift_clk,
  input wire logic i_serial_din,
  input wire logic i_load_outputs_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [8*RES_BITS-1:0] o_dac_codes,
  output logic [7:0] o_chan_pwrdn,
  output logic [7:0] o_out_en_n,
  output logic [1:0] o_ref_buffered,
  output logic [1:0] o_ref_supply,
  output logic [1:0] o_gain_double
);
  localparam int W = `ODSC_WORD_BITS;

  // two-stage synchronisers for the pins; reset loads the idle levels
  // so that no false shift clock edge or frame end follows reset
  logic sel_s1_q, sel_s2_q, clk_s1_q, clk_s2_q;
  logic din_s1_q, din_s2_q, ldn_s1_q, ldn_s2_q;
  logic sel_n_q, sclk_q, sclk_old_q, din_q, ldn_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      clk_s1_q <= 1'b1;
      clk_s2_q <= 1'b1;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      ldn_s1_q <= 1'b1;
      ldn_s2_q <= 1'b1;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b1;
      sclk_old_q <= 1'b1;
      din_q <= 1'b0;
      ldn_q <= 1'b1;
    end else begin
      sel_s1_q <= i_frame_sel_n;
      sel_s2_q <= sel_s1_q;
      clk_s1_q <= i_shift_clk;
      clk_s2_q <= clk_s1_q;
      din_s1_q <= i_serial_din;
      din_s2_q <= din_s1_q;
      ldn_s1_q <= i_load_outputs_n;
      ldn_s2_q <= ldn_s1_q;
      sel_n_q <= sel_s2_q;
      sclk_q <= clk_s2_q;
      sclk_old_q <= sclk_q;
      din_q <= din_s2_q;
      ldn_q <= ldn_s2_q;
    end
  end

  // frame assembly
  logic [W-1:0] shift_q;
  logic [4:0] count_q;
  logic sel_old_q;
  wire sclk_fall = sclk_old_q & ~sclk_q;
  wire frame_on = ~sel_n_q;
  wire take_bit = frame_on & sclk_fall & (count_q < 5'h10);
  wire frame_end = sel_n_q & ~sel_old_q;
  wire word_ok = frame_end & (count_q == 5'h10);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      sel_old_q <= 1'b1;
    end else begin
      sel_old_q <= sel_n_q;
      if (sel_n_q) begin
        count_q <= 5'h00;
      end else if (take_bit) begin
        shift_q <= {shift_q[W-2:0], din_q};
        count_q <= count_q + 5'h01;
      end
    end
  end

  // word decode
  function automatic logic mode_is(input logic [1:0] bits,
                                   input odsc_pkg::odsc_mode_type m);
    return bits == 2'(m);
  endfunction : mode_is

  wire is_cmd = shift_q[`ODSC_BIT_CMD];
  wire [2:0] chan_addr = shift_q[`ODSC_ADDR_HI:`ODSC_ADDR_LO];
  wire [RES_BITS-1:0] code_in = shift_q[11 -: RES_BITS];
  wire [1:0] mode_bits = shift_q[`ODSC_MODE_HI:`ODSC_MODE_LO];
  wire do_data = word_ok & ~is_cmd;
  wire do_rg = word_ok & is_cmd & mode_is(mode_bits, odsc_pkg::ODSC_MODE_REFGAIN);
  wire do_load = word_ok & is_cmd & mode_is(mode_bits, odsc_pkg::ODSC_MODE_LOAD);
  wire do_pd = word_ok & is_cmd & mode_is(mode_bits, odsc_pkg::ODSC_MODE_PWRDN);
  wire do_rst = word_ok & is_cmd & mode_is(mode_bits, odsc_pkg::ODSC_MODE_RESET);
  wire full_rst = do_rst & shift_q[`ODSC_BIT_FULLRST];
  wire load_rsvd = shift_q[1:0] == 2'(odsc_pkg::ODSC_LOAD_RSVD);

  // control state
  logic [1:0] load_mode_q, buf_q, sup_q, gain_q;
  logic [7:0] pd_q;
  logic single_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || full_rst) begin
      load_mode_q <= `ODSC_RST_LOAD_MODE;
      buf_q <= {2{`ODSC_RST_CTRL}};
      sup_q <= {2{`ODSC_RST_CTRL}};
      gain_q <= {2{`ODSC_RST_CTRL}};
      pd_q <= 8'h00;
      single_q <= 1'b0;
    end else begin
      single_q <= 1'b0;
      if (do_rg) begin
        buf_q <= {shift_q[`ODSC_BIT_BUF_EH], shift_q[`ODSC_BIT_BUF_AD]};
        gain_q <= {shift_q[`ODSC_BIT_GAIN_EH], shift_q[`ODSC_BIT_GAIN_AD]};
        sup_q <= {shift_q[`ODSC_BIT_SUP_EH], shift_q[`ODSC_BIT_SUP_AD]};
      end
      if (do_load && !load_rsvd) begin
        if (shift_q[1:0] == 2'(odsc_pkg::ODSC_LOAD_SINGLE)) begin
          single_q <= 1'b1;
        end else begin
          load_mode_q <= shift_q[1:0];
        end
      end
      if (do_pd) begin
        pd_q <= pd_q | shift_q[7:0];
      end
    end
  end

  // input and dac register banks
  logic [RES_BITS-1:0] in_q [8];
  logic [RES_BITS-1:0] dac_q [8];
  logic [7:0] fresh_q;
  wire transparent = (load_mode_q == 2'(odsc_pkg::ODSC_LOAD_CONT)) | ~ldn_q | single_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || do_rst) begin
      for (int i = 0; i < 8; i++) begin
        in_q[i] <= '0;
        dac_q[i] <= '0;
      end
      fresh_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (do_data && chan_addr == 3'(i)) begin
          in_q[i] <= code_in;
          fresh_q[i] <= 1'b1;
        end else if (transparent && fresh_q[i]) begin
          dac_q[i] <= in_q[i];
          fresh_q[i] <= 1'b0;
        end
      end
    end
  end

  // analog side outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_dac_codes <= '0;
      o_chan_pwrdn <= 8'h00;
      o_out_en_n <= 8'h00;
      o_ref_buffered <= 2'h0;
      o_ref_supply <= 2'h0;
      o_gain_double <= 2'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        o_dac_codes[i*RES_BITS +: RES_BITS] <= dac_q[i];
      end
      o_chan_pwrdn <= pd_q;
      o_out_en_n <= pd_q;
      o_ref_buffered <= buf_q & ~sup_q;
      o_ref_supply <= sup_q;
      o_gain_double <= gain_q & ~sup_q;
    end
  end

  // axi4-lite slave: ctrl reads the settings, status the frame state
  logic aw_hold_q, w_hold_q;
  logic [31:0] aw_addr_q;
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire rd_is_ctrl = s_axi_araddr == `ODSC_REG_CTRL;
  wire rd_is_status = s_axi_araddr == `ODSC_REG_STATUS;
  // only channels A to D are visible on the bus
  wire rd_is_code = (s_axi_araddr & 32'hffff_fff3) == `ODSC_REG_CODE0;
  wire rd_hit = rd_is_ctrl | rd_is_status | rd_is_code;
  wire [31:0] ctrl_word = {16'h0000, pd_q, gain_q, buf_q, sup_q, load_mode_q};
  wire [31:0] rd_word = rd_is_ctrl ? ctrl_word :
    rd_is_status ? {27'h0000000, count_q} :
    rd_is_code ? 32'(dac_q[s_axi_araddr[3:2]]) : 32'h0000_0000;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h2; // all registers read only
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  a_partial_drop: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (frame_end && count_q != 5'h10) |=> $stable(fresh_q))
    else $error("partial frame changed channel state");
  a_supply_unity: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ##1 (o_gain_double & o_ref_supply) == 2'h0)
    else $error("gain doubled under supply reference");
  a_supply_unbuf: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ##1 (o_ref_buffered & o_ref_supply) == 2'h0)
    else $error("buffered under supply reference");
  a_data_lands: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (do_data && !do_rst) |=> in_q[$past(chan_addr)] == $past(code_in))
    else $error("data write missed input register");
  a_pd_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    do_pd |=> ((pd_q & $past(shift_q[7:0])) == $past(shift_q[7:0])))
    else $error("selected channel not powered down");
  a_pd_float: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(pd_q[0]) |=> o_out_en_n[0])
    else $error("powered down output still driven");
  a_reset_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    do_rst |=> (dac_q[0] == '0 && in_q[7] == '0))
    else $error("reset left data");
  a_full_reset: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    full_rst |=> (load_mode_q == `ODSC_RST_LOAD_MODE && pd_q == 8'h00))
    else $error("control not restored");
  a_count_cap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    count_q <= 5'h10)
    else $error("bit count beyond word");

  // frame and decode checks
  a_frame_idle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    sel_n_q |=> (count_q == 5'h00))
    else $error("bit count kept outside frame");
  a_shift_msb: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    take_bit |=> (shift_q[0] == $past(din_q)))
    else $error("sampled bit not shifted in");
  a_count_step: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    take_bit |=> (count_q == $past(count_q) + 5'h01))
    else $error("bit count did not advance");
  a_extra_edges: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (count_q == 5'h10 && !sel_n_q) |=> $stable(shift_q))
    else $error("word shifted beyond sixteen bits");
  a_rsvd_ignored: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (do_load && load_rsvd) |=> $stable(load_mode_q))
    else $error("reserved load mode taken");
  a_single_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    single_q |=> !single_q)
    else $error("single update longer than one cycle");
  a_rg_buf: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    do_rg |=> (buf_q == $past({shift_q[`ODSC_BIT_BUF_EH], shift_q[`ODSC_BIT_BUF_AD]})))
    else $error("buffer bits not applied");
  a_rg_gain: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    do_rg |=> (gain_q == $past({shift_q[`ODSC_BIT_GAIN_EH], shift_q[`ODSC_BIT_GAIN_AD]})))
    else $error("gain bits not applied");
  a_rg_supply: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    do_rg |=> (sup_q == $past({shift_q[`ODSC_BIT_SUP_EH], shift_q[`ODSC_BIT_SUP_AD]})))
    else $error("supply bits not applied");
  a_ctrl_default: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    full_rst |=> (buf_q == 2'h0 && gain_q == 2'h0 && sup_q == 2'h0))
    else $error("group settings not restored");
  a_unsel_keep: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    do_pd |=> ((pd_q & ~$past(shift_q[7:0])) == $past(pd_q & ~shift_q[7:0])))
    else $error("unselected channel changed state");
  a_data_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    do_rst |=> (in_q[3] == {RES_BITS{1'b0}} && dac_q[4] == {RES_BITS{1'b0}}))
    else $error("data reset left a code");

  // bank and output checks
  a_data_pd: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (do_data && chan_addr == 3'h0 && pd_q[0]) |=> (in_q[0] == $past(code_in)))
    else $error("write refused while powered down");
  a_held_latch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (load_mode_q == 2'(odsc_pkg::ODSC_LOAD_HELD) && ldn_q && !single_q && !do_rst)
    |=> $stable(dac_q[0]))
    else $error("latched dac register changed");
  a_cont_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (load_mode_q == 2'(odsc_pkg::ODSC_LOAD_CONT) && fresh_q[0] && !do_data && !do_rst)
    |=> (dac_q[0] == $past(in_q[0])))
    else $error("dac register did not follow input");
  a_pd_mirror: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_out_en_n == o_chan_pwrdn)
    else $error("output enable disagrees with power-down");
  a_code_out: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_dac_codes[RES_BITS-1:0] == $past(dac_q[0]))
    else $error("channel code not presented");
  a_supply_out: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_ref_supply == $past(sup_q))
    else $error("supply setting not presented");
endmodule : odsc_top

// >>> bench/odsc_host.sv
// host serial master model that frames words into the dac front end
`timescale 1ns/1ps
module odsc_host (
  output logic o_frame_sel_n,
  output logic o_shift_clk,
  output logic o_serial_din
);
  initial begin
    o_frame_sel_n = 1'b1;
    o_shift_clk = 1'b1;
    o_serial_din = 1'b0;
  end
  // shift clock idles high between frames; data flips once released
  task automatic send(input logic [15:0] word, input int edges);
    o_frame_sel_n <= 1'b0;
    for (int i = 0; i < edges; i++) begin
      o_serial_din <= word[15-i];
      #62.5 o_shift_clk <= 1'b0;
      #62.5 o_shift_clk <= 1'b1;
    end
    #62.5 o_frame_sel_n <= 1'b1;
    o_serial_din <= ~o_serial_din;
  endtask : send
endmodule : odsc_host

// >>> bench/tb_top.sv
// self-checking bench for the octal dac serial front end
`timescale 1ns/1ps
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ld_n = 1'b1;
  logic sel_n, sclk, din;
  logic [31:0] awaddr = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rbuf, rsup, gain;
  logic [95:0] codes;
  logic [7:0] pd, oen_n;
  int errors = 0;
  int comparisons = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  odsc_host odsc_host_inst (.o_frame_sel_n(sel_n), .o_shift_clk(sclk), .o_serial_din(din));
  odsc_top odsc_top_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_frame_sel_n(sel_n), .i_shift_clk(sclk), .i_serial_din(din), .i_load_outputs_n(ld_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(32'h0), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .o_dac_codes(codes), .o_chan_pwrdn(pd), .o_out_en_n(oen_n), .o_ref_buffered(rbuf),
    .o_ref_supply(rsup), .o_gain_double(gain));
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_rd(input logic [31:0] a, output logic [33:0] rd);
    @(posedge i_clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = {rresp, rdata};
    rready <= 1'b0;
  endtask : axi_rd
  task automatic axi_wr(input logic [31:0] a, output logic [1:0] r);
    @(posedge i_clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic frame(input logic [15:0] w, input int n);
    odsc_host_inst.send(w, n);
    repeat (12) @(posedge i_clk_sys);
  endtask : frame
  task automatic t_power_on;
    logic [33:0] rd;
    logic [1:0] r;
    chk(codes, 96'h0);
    chk({pd, oen_n, rbuf, rsup, gain}, 22'h0);
    axi_rd(32'h0, rd);
    chk(rd, 34'h1);
    axi_rd(32'h100, rd);
    chk(rd, {2'h2, 32'h0});
    axi_wr(32'h0, r);
    chk(r, 2'h2);
    $display("test power_on done");
  endtask : t_power_on
  task automatic t_data;
    logic [33:0] rd;
    for (int k = 0; k < 8; k++) frame({1'b0, 3'(k), 12'(k * 12'h249)}, 16);
    chk(codes, 96'h0);
    @(posedge i_clk_sys) ld_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    ld_n <= 1'b1;
    for (int k = 0; k < 8; k++) chk(codes[k*12 +: 12], 12'(k * 12'h249));
    axi_rd(32'h14, rd);
    chk(rd, 34'h249);
    $display("test data done");
  endtask : t_data
  task automatic t_load;
    logic [33:0] rd;
    frame(16'ha000, 16);
    frame(16'h0123, 16);
    chk(codes[11:0], 12'h123);
    frame(16'h0abc, 15);
    chk(codes[11:0], 12'h123);
    frame(16'ha001, 16);
    frame(16'h0456, 16);
    chk(codes[11:0], 12'h123);
    frame(16'ha003, 16);
    axi_rd(32'h0, rd);
    chk(rd[1:0], 2'h1);
    frame(16'ha002, 16);
    chk(codes[11:0], 12'h456);
    $display("test load done");
  endtask : t_load
  task automatic t_refgain;
    logic [15:0] w[3] = '{16'h803c, 16'h803f, 16'h8035};
    logic [5:0] e[3] = '{6'b00_11_11, 6'b11_00_00, 6'b01_00_10};
    for (int i = 0; i < 3; i++) begin
      frame(w[i], 16);
      chk({rsup, rbuf, gain}, e[i]);
    end
    $display("test refgain done");
  endtask : t_refgain
  task automatic t_pwrdn;
    frame(16'hc0a5, 16);
    chk({pd, oen_n}, 16'ha5a5);
    @(posedge i_clk_sys) ld_n <= 1'b0;
    frame(16'h0321, 16);
    chk(codes[11:0], 12'h321);
    ld_n <= 1'b1;
    frame(16'hc05a, 16);
    chk({pd, oen_n}, 16'hffff);
    $display("test pwrdn done");
  endtask : t_pwrdn
  task automatic t_reset_cmd;
    logic [33:0] rd;
    frame(16'he000, 16);
    chk({codes, pd}, {96'h0, 8'hff});
    frame(16'hf000, 16);
    chk({codes, pd, oen_n, rbuf, rsup, gain}, 118'h0);
    axi_rd(32'h0, rd);
    chk(rd, 34'h1);
    $display("test reset_cmd done");
  endtask : t_reset_cmd
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    #500us;
    errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    t_power_on;
    t_data;
    t_load;
    t_refgain;
    t_pwrdn;
    t_reset_cmd;
    end_of_test;
  end
endmodule : tb_top
